// ### src/apv_pin_widget.sv
// Verb responder for the digital display audio pin complex widget
//
// Notes on behaviour
// - Amp set payload: output select 15, input select 14, left 13, right 12, index 11:8, mute 7.
// - Amp get answers a 32-bit word with only the mute flag at bit 7, muted after reset.
// - Parameter read picks widget caps 09h, pin caps 0Ch, list length 0Eh, power 0Fh, amp 12h.
// - Widget caps report type 4h in bits 23:20, no delay, and extension 011 with stereo.
// - Widget caps set power control, digital, connection list and unsolicited bits 10 to 7.
// - Widget caps set bits 3 and 2 and clear protection, swap, processing, stripe, format, in amp.
// - Pin caps set bits 27, 24 and 7 and clear the multi-stream bit 25.
// - Pin caps set output capable bit 4 and presence detect bit 2; only bits 27, 24 and 7 are set besides.
// - List length word is short form with length 03h in bits 6:0, upper bits zero.
// - Output amp caps set only the mute capable bit 31.
// - Power states word sets bits 31, 3 and 0 and clears the D2 and D1 bits.
// - An 8-bit input selector, reset 00h, is written by the set verb and read by the get verb.
// - List entry read returns converters 4, 3 and 2 in bytes 2, 1 and 0, byte 3 zero.
// - Power read returns actual state in bits 5:4 and requested in bits 1:0, both reset 11.
// - Power read always returns settings reset, clock stop and error bits 10 to 8 as zero.
`timescale 1ns/100ps
module apv_pin_widget #(
    parameter int SETTLE_CYCLES = apv_pkg::PWR_SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Verb in
    input wire logic cmd_valid,
    input wire logic [19:0] cmd_data,
    // Response out
    output logic resp_valid,
    output logic [31:0] resp_data,
    // Widget state
    output logic mute_left,
    output logic mute_right,
    output logic [7:0] input_select_value,
    output logic [1:0] requested_power,
    output logic [1:0] actual_power
);
    localparam int CW = $clog2(SETTLE_CYCLES + 1);

    // A zero wait would never let the actual state follow a request
    if (SETTLE_CYCLES < 1) begin : g_bad_settle
        $error("SETTLE_CYCLES must be at least 1");
    end

    // Verb decode
    wire logic [3:0] verb4 = cmd_data[19:16];
    wire logic [11:0] verb12 = cmd_data[19:8];
    wire logic [7:0] payload8 = cmd_data[7:0];
    wire logic [15:0] payload16 = cmd_data[15:0];
    wire logic is_amp_set = cmd_valid && (verb4 == apv_pkg::VERB4_AMP_SET);
    wire logic is_amp_get = cmd_valid && (verb4 == apv_pkg::VERB4_AMP_GET);
    wire logic is_long = cmd_valid && !is_amp_set && !is_amp_get;
    wire logic is_param = is_long && (verb12 == apv_pkg::VERB_PARAM_GET);
    wire logic is_sel_set = is_long && (verb12 == apv_pkg::VERB_SEL_SET);
    wire logic is_sel_get = is_long && (verb12 == apv_pkg::VERB_SEL_GET);
    wire logic is_list_get = is_long && (verb12 == apv_pkg::VERB_LIST_GET);
    wire logic is_pwr_set = is_long && (verb12 == apv_pkg::VERB_PWR_SET);
    wire logic is_pwr_get = is_long && (verb12 == apv_pkg::VERB_PWR_GET);

    // Amp set fields; the pin has only an output amp at index 0
    wire logic amp_out_sel = payload16[apv_pkg::AMP_OUT_SEL_BIT];
    wire logic amp_in_sel = payload16[apv_pkg::AMP_IN_SEL_BIT];
    wire logic amp_left_sel = payload16[apv_pkg::AMP_LEFT_SEL_BIT];
    wire logic amp_right_sel = payload16[apv_pkg::AMP_RIGHT_SEL_BIT];
    wire logic [3:0] amp_index = payload16[apv_pkg::AMP_INDEX_LSB +: 4];
    wire logic amp_mute = payload16[apv_pkg::AMP_MUTE_BIT];
    // Input amp selects are dropped: no input amp exists to change
    wire logic amp_hit = is_amp_set && amp_out_sel && (amp_index == 4'h0);
    wire logic next_mute_left = (amp_hit && amp_left_sel) ? amp_mute : mute_left;
    wire logic next_mute_right = (amp_hit && amp_right_sel) ? amp_mute : mute_right;
    wire logic unused_in_sel = amp_in_sel;

    // Amp get: bit 13 picks left, otherwise right
    wire logic amp_get_mute = amp_left_sel ? mute_left : mute_right;
    wire logic [31:0] amp_word = {24'h00_0000, amp_get_mute, 7'h00};

    // Parameter words are constants
    wire logic [31:0] param_word =
        (payload8 == apv_pkg::PARAM_WIDGET_CAPS) ?
            apv_pkg::WIDGET_CAPS_WORD :
        (payload8 == apv_pkg::PARAM_PIN_CAPS) ? apv_pkg::PIN_CAPS_WORD :
        (payload8 == apv_pkg::PARAM_LIST_LEN) ? apv_pkg::LIST_LEN_WORD :
        (payload8 == apv_pkg::PARAM_POWER_STATES) ? apv_pkg::POWER_STATES_WORD :
        (payload8 == apv_pkg::PARAM_OUT_AMP_CAPS) ? apv_pkg::OUT_AMP_CAPS_WORD :
        32'h0000_0000;

    // Power state handling
    wire logic [1:0] req_state = payload8[1:0];
    wire logic req_ok = (req_state == apv_pkg::PWR_D0) || (req_state == apv_pkg::PWR_D3);
    wire logic pwr_accept = is_pwr_set && req_ok;
    wire logic [31:0] pwr_word = {21'h00_0000, 3'b000, 2'b00, actual_power, 2'b00,
        requested_power};

    // Settling counter: zero means idle
    logic [CW-1:0] settle_count;
    wire logic settle_done = (settle_count == CW'(1));
    wire logic [CW-1:0] next_settle_count =
        pwr_accept ? CW'(SETTLE_CYCLES) :
        (settle_count != '0) ? settle_count - CW'(1) : '0;
    // A request landing on the done cycle restarts the wait, so actual tracks the newest one
    wire logic [1:0] next_actual = (settle_done && !pwr_accept) ? requested_power : actual_power;

    wire logic [31:0] next_resp =
        is_amp_get ? amp_word :
        is_param ? param_word :
        is_sel_get ? {24'h00_0000, input_select_value} :
        is_list_get ? apv_pkg::LIST_ENTRY_WORD :
        is_pwr_get ? pwr_word :
        32'h0000_0000;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            resp_valid <= 1'b0;
            resp_data <= 32'h0000_0000;
        end else begin
            resp_valid <= cmd_valid;
            resp_data <= next_resp;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mute_left <= apv_pkg::AMP_MUTE_RESET;
            mute_right <= apv_pkg::AMP_MUTE_RESET;
            input_select_value <= apv_pkg::INPUT_SELECT_RESET;
        end else begin
            mute_left <= next_mute_left;
            mute_right <= next_mute_right;
            if (is_sel_set) begin
                input_select_value <= payload8;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            requested_power <= apv_pkg::PWR_RESET;
            actual_power <= apv_pkg::PWR_RESET;
            settle_count <= '0;
        end else begin
            if (pwr_accept) begin
                requested_power <= req_state;
            end
            actual_power <= next_actual;
            settle_count <= next_settle_count;
        end
    end
endmodule : apv_pin_widget

// ### src/apv_pkg.sv
// Constants for the pin widget verb responder
package apv_pkg;
    // Verb codes: 4-bit verbs sit in cmd bits 19:16, 12-bit verbs in bits 19:08
    localparam logic [3:0] VERB4_AMP_SET = 4'h3;
    localparam logic [3:0] VERB4_AMP_GET = 4'hB;
    localparam logic [11:0] VERB_PARAM_GET = 12'hF00;
    localparam logic [11:0] VERB_SEL_SET = 12'h701;
    localparam logic [11:0] VERB_SEL_GET = 12'hF01;
    localparam logic [11:0] VERB_LIST_GET = 12'hF02;
    localparam logic [11:0] VERB_PWR_SET = 12'h705;
    localparam logic [11:0] VERB_PWR_GET = 12'hF05;

    // Parameter identifiers
    localparam logic [7:0] PARAM_WIDGET_CAPS = 8'h09;
    localparam logic [7:0] PARAM_PIN_CAPS = 8'h0C;
    localparam logic [7:0] PARAM_LIST_LEN = 8'h0E;
    localparam logic [7:0] PARAM_POWER_STATES = 8'h0F;
    localparam logic [7:0] PARAM_OUT_AMP_CAPS = 8'h12;

    // Amp set payload fields
    localparam int AMP_OUT_SEL_BIT = 15;
    localparam int AMP_IN_SEL_BIT = 14;
    localparam int AMP_LEFT_SEL_BIT = 13;
    localparam int AMP_RIGHT_SEL_BIT = 12;
    localparam int AMP_INDEX_LSB = 8;
    localparam int AMP_MUTE_BIT = 7;
    localparam logic AMP_MUTE_RESET = 1'b1;

    // Fixed parameter words
    localparam logic [3:0] WIDGET_TYPE_PIN = 4'h4;
    localparam logic [2:0] CHAN_COUNT_EXT = 3'b011;
    localparam logic [31:0] WIDGET_CAPS_WORD = {8'h00, WIDGET_TYPE_PIN, 4'h0,
        CHAN_COUNT_EXT, 13'b0_0111_1000_1101};
    localparam logic [31:0] PIN_CAPS_WORD = 32'h0900_0094;
    localparam logic [31:0] LIST_LEN_WORD = 32'h0000_0003;
    localparam logic [31:0] OUT_AMP_CAPS_WORD = 32'h8000_0000;
    localparam logic [31:0] POWER_STATES_WORD = 32'h8000_0009;
    localparam logic [31:0] LIST_ENTRY_WORD = 32'h0004_0302;

    // Selector and power state
    localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
    localparam logic [1:0] PWR_D0 = 2'b00;
    localparam logic [1:0] PWR_D3 = 2'b11;
    localparam logic [1:0] PWR_RESET = 2'b11;
    localparam int PWR_ACTUAL_LSB = 4;

    // Internal settling time of a power transition
    localparam int CLK_PERIOD_NS = 100;
    localparam int PWR_SETTLE_NS = 1000;
    localparam int PWR_SETTLE_CYCLES = (PWR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : apv_pkg

// ### testbench/apv_ctrl_model.sv
// Controller model issuing verbs to the pin widget
`timescale 1ns/100ps
module apv_ctrl_model (
    input wire logic clk_sys,
    output logic cmd_valid = 1'b0,
    output logic [19:0] cmd_data = 20'h00000
);
    // Power sets carry D0 or D3 unless a test asks otherwise
    // Idle data flips each cycle so stale bits never pass as a verb
    task drive(input logic v, input logic [19:0] c);
        cmd_valid = v;
        cmd_data = v ? c : ~cmd_data;
        @(posedge clk_sys) #1;
    endtask : drive
endmodule : apv_ctrl_model

// ### testbench/apv_pin_widget_chk.sv
// Port checks for the pin widget verb responder
`timescale 1ns/100ps
module apv_pin_widget_chk (
    input wire logic clk_sys, rst_b, cmd_valid, resp_valid, mute_left, mute_right,
    input wire logic [19:0] cmd_data,
    input wire logic [31:0] resp_data,
    input wire logic [7:0] input_select_value,
    input wire logic [1:0] requested_power, actual_power
);
    wire logic t = cmd_valid;
    wire logic [11:0] v = cmd_data[19:8];
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    chk_answer_next: assert property (t |=> resp_valid) else $error("late");
    chk_answer_only: assert property (!t |=> !resp_valid) else $error("stray");
    chk_widget_word: assert property (t && cmd_data == 20'hF0009 |=>
        resp_data == 32'h0040678D) else $error("caps");
    chk_list_entry: assert property (t && v == 12'hF02 |=>
        resp_data == 32'h00040302) else $error("entry");
    chk_select_write: assert property (t && v == 12'h701 |=>
        input_select_value == $past(cmd_data[7:0])) else $error("select");
    chk_power_read: assert property (t && v == 12'hF05 |=> resp_data ==
        {26'h0, $past(actual_power), 2'h0, $past(requested_power)}) else $error("power");
    chk_power_ignore: assert property (t && v == 12'h705 && ^cmd_data[1:0] |=>
        $stable(requested_power)) else $error("odd request");
    chk_mute_left: assert property (t && cmd_data[19:15] == 5'h07 && cmd_data[13] &&
        cmd_data[11:8] == 4'h0 |=> mute_left == $past(cmd_data[7])) else $error("mute");
    cover property (t && v == 12'h705);
    cover property (t && cmd_data[19:16] == 4'hB);
    cover property (t && v == 12'h701);
endmodule : apv_pin_widget_chk
bind apv_pin_widget apv_pin_widget_chk chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .resp_valid(resp_valid), .mute_left(mute_left),
    .mute_right(mute_right), .cmd_data(cmd_data), .resp_data(resp_data),
    .input_select_value(input_select_value), .requested_power(requested_power),
    .actual_power(actual_power));

// ### testbench/tb_top.sv
// Bench for the pin widget verb responder
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] %0t %h %h", $time, a, e); end end
module tb_top;
    localparam int N = 3;
    logic clk_sys = 1'b0, rst_b = 1'b0, cmd_valid, resp_valid, mute_left, mute_right;
    logic [19:0] cmd_data, cmds [18] = '{20'hF0500, 20'h70501, 20'h70502, 20'hF0500, 20'hB2000,
        20'hF0009, 20'hF000C, 20'hF000E, 20'hF000F, 20'hF0012, 20'hF0055, 20'hF0200,
        20'h3A000, 20'h33000, 20'h3B100, 20'h37000, 20'hB2000, 20'hB1000};
    logic [31:0] resp_data, exp_q[$], exps [18] = '{32'h33, 32'h0, 32'h0, 32'h33, 32'h80,
        32'h40678D, 32'h9000094, 32'h3, 32'h80000009, 32'h80000000, 32'h0, 32'h40302,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h80};
    logic [7:0] input_select_value, r;
    logic [1:0] requested_power, actual_power;
    int fail_count = 0, compares = 0, cyc = 0, seed = 32'hD114;
    initial forever #50 clk_sys = ~clk_sys;
    apv_ctrl_model m (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_data(cmd_data));
    apv_pin_widget #(.SETTLE_CYCLES(N)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .cmd_valid(cmd_valid), .cmd_data(cmd_data), .resp_valid(resp_valid),
        .resp_data(resp_data), .mute_left(mute_left), .mute_right(mute_right),
        .input_select_value(input_select_value), .requested_power(requested_power),
        .actual_power(actual_power));
    task vb(input logic [19:0] c, input logic [31:0] e);
        exp_q.push_back(e);
        m.drive(1'b1, c);
    endtask : vb
    task close_out;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    // Empty queue reads as unknown, so an extra answer counts as a mismatch
    always @(negedge clk_sys) begin
        if (resp_valid !== 1'b0) `CHK(resp_data, exp_q[0]);
        if (resp_valid !== 1'b0) exp_q.pop_front();
        cyc++;
        if (cyc == 400) fail_count++;
        if (cyc == 400) close_out;
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        @(posedge clk_sys);
        #1 `CHK({mute_left, mute_right, input_select_value}, 10'h300);
        foreach (cmds[i])
            vb(cmds[i], exps[i]);
        repeat (4) begin
            r = 8'($random(seed));
            vb({12'h701, r}, 32'h0);
            vb({12'hF01, r}, {24'h0, r});
        end
        $display("fixed and select verbs done");
        vb(20'h70500, 32'h0);
        m.drive(1'b0, 20'h0);
        `CHK({requested_power, actual_power}, 4'h3);
        repeat (N - 1) m.drive(1'b0, 20'h0);
        `CHK(actual_power, 2'h0);
        vb(20'hF0500, 32'h0);
        m.drive(1'b0, 20'h0);
        $display("power done");
        rst_b = 1'b0;
        m.drive(1'b0, 20'h0);
        rst_b = 1'b1;
        m.drive(1'b0, 20'h0);
        `CHK({mute_left, mute_right, input_select_value, requested_power, actual_power},
            14'h300F);
        $display("mid-run reset done");
        close_out;
    end
endmodule : tb_top
